// *** design/ida_params.svh ***
`ifndef IDA_PARAMS_SVH
`define IDA_PARAMS_SVH

// indirect data port location in the data map
`define IDA_PORT_ADDR 8'h00
// pointer register location in the data map
`define IDA_PTR_ADDR 8'h04
// status register location (bank-select lives in bit 7)
`define IDA_STATUS_ADDR 8'h03
`define IDA_BANK_BIT 7
`define IDA_PTR_RST 8'h00
`define IDA_SELF_READ 8'h00

`endif

// *** design/ida_pkg.sv ***
package ida_pkg;
	typedef logic [7:0] ida_byte_t;
	typedef logic [8:0] ida_eaddr_t;
endpackage

// *** design/ida_ptr.sv ***
`timescale 1ns/1ps
`include "ida_params.svh"

module ida_ptr
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic wr_en,
	input wire ida_pkg::ida_byte_t wr_data,
	output ida_pkg::ida_byte_t ptr_value
);
	ida_pkg::ida_byte_t ptr_reg;

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			ptr_reg <= `IDA_PTR_RST;
		else if (wr_en)
			ptr_reg <= wr_data;
	end

	assign ptr_value = ptr_reg;
endmodule

// *** design/ida_top.sv ***
`timescale 1ns/1ps
`include "ida_params.svh"

// How it works
// - the indirect data port holds no storage and any access to it becomes an indirect access.
// - an access naming the port is carried out on the location held in the pointer register.
// - reading the port while the pointer names the port itself returns 00h.
// - writing the port while the pointer names the port itself changes no location.
// - the effective address is 9 bits, bank-select bit above the 8-bit target.
// - the bank-select bit reaches only eff_addr; mem_addr carries the 8-bit target alone.

module ida_top
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire ida_pkg::ida_byte_t core_addr,
	input wire logic core_rd,
	input wire logic core_wr,
	input wire ida_pkg::ida_byte_t core_wdata,
	input wire logic bank_select_in,
	input wire ida_pkg::ida_byte_t mem_rdata,
	output ida_pkg::ida_byte_t core_rdata,
	output logic core_rvalid,
	output ida_pkg::ida_byte_t mem_addr,
	output logic mem_rd,
	output logic mem_wr,
	output ida_pkg::ida_byte_t mem_wdata,
	output ida_pkg::ida_eaddr_t eff_addr,
	output ida_pkg::ida_byte_t file_select_pointer
);
	// ----------------------------------------
	// address decoding
	// ----------------------------------------
	function automatic logic is_port(input ida_pkg::ida_byte_t a);
		is_port = (a == `IDA_PORT_ADDR);
	endfunction

	function automatic logic is_ptr(input ida_pkg::ida_byte_t a);
		is_ptr = (a == `IDA_PTR_ADDR);
	endfunction

	// ----------------------------------------
	// resolution nets
	// ----------------------------------------
	ida_pkg::ida_byte_t ptr_value;
	wire indirect;
	wire self_ref;
	wire ptr_hit;
	wire ptr_wr;
	wire wr_ok;
	wire rd_ok;
	wire ida_pkg::ida_byte_t target;
	wire ida_pkg::ida_eaddr_t eff_next;
	wire ida_pkg::ida_byte_t rdata_next;
	wire ida_pkg::ida_byte_t fsp_next;

	// ----------------------------------------
	// output registers
	// ----------------------------------------
	// every port comes from a flop, so the core sees answers one cycle late
	ida_pkg::ida_byte_t mem_addr_reg;
	logic mem_rd_reg;
	logic mem_wr_reg;
	ida_pkg::ida_byte_t mem_wdata_reg;
	ida_pkg::ida_eaddr_t eff_addr_reg;
	ida_pkg::ida_byte_t core_rdata_reg;
	logic core_rvalid_reg;
	ida_pkg::ida_byte_t fsp_reg;

	// ----------------------------------------
	// pointer register
	// ----------------------------------------
	// plain pointer register
	ida_ptr u_ptr
	(
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.wr_en(ptr_wr),
		.wr_data(core_wdata),
		.ptr_value(ptr_value)
	);

	// ----------------------------------------
	// address resolution
	// ----------------------------------------
	// port access redirected
	assign indirect = is_port(core_addr);
	assign target = indirect ? ptr_value : core_addr;
	assign self_ref = indirect && is_port(ptr_value);
	assign ptr_hit = is_ptr(target);
	assign ptr_wr = core_wr && ptr_hit;
	// self write suppressed
	// pointer writes stay out of memory, one owner per location
	assign wr_ok = core_wr && !self_ref && !ptr_hit;
	assign rd_ok = core_rd && !self_ref;
	assign eff_next = {bank_select_in, target};

	// ----------------------------------------
	// read data and pointer mirror
	// ----------------------------------------
	// memory answers within the request cycle; no wait state is inserted
	// self read zero
	assign rdata_next = self_ref ? `IDA_SELF_READ : (ptr_hit ? ptr_value : mem_rdata);
	// a read in the cycle of a pointer write still sees the old pointer
	assign fsp_next = ptr_wr ? core_wdata : ptr_value;

	// ----------------------------------------
	// registered outputs
	// ----------------------------------------
	// bank bit ignored
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			mem_addr_reg <= 8'h00;
		end
		else
		begin
			mem_addr_reg <= target;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			mem_rd_reg <= 1'b0;
		end
		else
		begin
			mem_rd_reg <= rd_ok;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			mem_wr_reg <= 1'b0;
		end
		else
		begin
			mem_wr_reg <= wr_ok;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			mem_wdata_reg <= 8'h00;
		end
		else
		begin
			mem_wdata_reg <= core_wdata;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			eff_addr_reg <= 9'h000;
		end
		else
		begin
			eff_addr_reg <= eff_next;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			core_rdata_reg <= 8'h00;
		end
		else
		begin
			core_rdata_reg <= rdata_next;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			core_rvalid_reg <= 1'b0;
		end
		else
		begin
			core_rvalid_reg <= core_rd;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			fsp_reg <= `IDA_PTR_RST;
		end
		else
		begin
			fsp_reg <= fsp_next;
		end
	end

	// ----------------------------------------
	// output ports
	// ----------------------------------------
	assign mem_addr = mem_addr_reg;
	assign mem_rd = mem_rd_reg;
	assign mem_wr = mem_wr_reg;
	assign mem_wdata = mem_wdata_reg;
	assign eff_addr = eff_addr_reg;
	assign core_rdata = core_rdata_reg;
	assign core_rvalid = core_rvalid_reg;
	assign file_select_pointer = fsp_reg;
endmodule

// *** bench/ida_mem_model.sv ***
`timescale 1ns/1ps
module ida_mem_model(
	input wire logic [7:0] core_addr,
	input wire logic [7:0] file_select_pointer,
	output logic [7:0] mem_rdata
);
	// pattern differs per location so a wrong target shows
	assign mem_rdata = (core_addr == 8'h00 ? file_select_pointer : core_addr) ^ 8'ha5;
endmodule

// *** bench/ida_top_props.sv ***
`timescale 1ns/1ps
module ida_top_props
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic core_rd,
	input wire logic core_wr,
	input wire logic bank_select_in,
	input wire logic core_rvalid,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [7:0] core_addr,
	input wire logic [7:0] core_wdata,
	input wire logic [7:0] core_rdata,
	input wire logic [7:0] mem_addr,
	input wire logic [7:0] file_select_pointer,
	input wire logic [8:0] eff_addr
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	wire ind = core_addr == 8'h00;
	wire slf = ind && file_select_pointer == 8'h00;
	wire via_ptr = ind && file_select_pointer == 8'h04;
	property p_ia;
		(core_rd || core_wr) && ind && !slf |=> mem_addr == $past(file_select_pointer);
	endproperty
	a_ia: assert property (p_ia) else $error("target");
	property p_z;
		core_rd && slf |=> core_rvalid && core_rdata == 8'h00 && !mem_rd;
	endproperty
	a_z: assert property (p_z) else $error("self read");
	property p_nw;
		core_wr && slf |=> !mem_wr;
	endproperty
	a_nw: assert property (p_nw) else $error("self write");
	property p_ea;
		(core_rd || core_wr) && ind |=> eff_addr == {$past(bank_select_in), mem_addr};
	endproperty
	a_ea: assert property (p_ea) else $error("eff addr");
	property p_no;
		mem_wr |-> mem_addr != 8'h00;
	endproperty
	a_no: assert property (p_no) else $error("port stored");
	property p_pt;
		core_wr && core_addr == 8'h04 |=> file_select_pointer == $past(core_wdata);
	endproperty
	a_pt: assert property (p_pt) else $error("pointer");
	property p_pi;
		core_wr && via_ptr |=> !mem_wr && file_select_pointer == $past(core_wdata);
	endproperty
	a_pi: assert property (p_pi) else $error("pointer via port");
	cover property (core_wr && slf);
	cover property (core_rd && slf);
	cover property (core_wr && core_addr == 8'h04 ##1 core_wr && ind);
	cover property (core_wr && via_ptr);
endmodule
bind ida_top ida_top_props props_u
(
	.clk_sys(clk_sys),
	.sys_rst(sys_rst),
	.core_rd(core_rd),
	.core_wr(core_wr),
	.bank_select_in(bank_select_in),
	.core_rvalid(core_rvalid),
	.mem_rd(mem_rd),
	.mem_wr(mem_wr),
	.core_addr(core_addr),
	.core_wdata(core_wdata),
	.core_rdata(core_rdata),
	.mem_addr(mem_addr),
	.file_select_pointer(file_select_pointer),
	.eff_addr(eff_addr)
);

// *** bench/indirect_data_addressing_tb.sv ***
`timescale 1ns/1ps
`define CHK(n,e,g) \
	begin \
		checked++; \
		if ((g) !== (e)) \
		begin \
			n_mismatch++; \
			$display("[ERR] %s exp %h got %h", n, e, g); \
		end \
	end
module indirect_data_addressing_tb;
	logic clk_sys = 1'b0, sys_rst = 1'b1, core_rd = 1'b0, core_wr = 1'b0, bank_select_in = 1'b1;
	logic core_rvalid, mem_rd, mem_wr;
	logic [7:0] core_addr = 8'h00, core_wdata = 8'h00, mem_rdata, core_rdata, mem_addr, mem_wdata;
	logic [7:0] file_select_pointer;
	logic [8:0] eff_addr;
	int n_mismatch = 0, checked = 0;
	always #12.5 clk_sys = ~clk_sys;
	ida_top dut_u
	(
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.core_addr(core_addr),
		.core_rd(core_rd),
		.core_wr(core_wr),
		.core_wdata(core_wdata),
		.bank_select_in(bank_select_in),
		.mem_rdata(mem_rdata),
		.core_rdata(core_rdata),
		.core_rvalid(core_rvalid),
		.mem_addr(mem_addr),
		.mem_rd(mem_rd),
		.mem_wr(mem_wr),
		.mem_wdata(mem_wdata),
		.eff_addr(eff_addr),
		.file_select_pointer(file_select_pointer)
	);
	ida_mem_model mdl_u
	(
		.core_addr(core_addr),
		.file_select_pointer(file_select_pointer),
		.mem_rdata(mem_rdata)
	);
	task acc(input logic [7:0] a, d, input logic w);
		@(posedge clk_sys);
		core_addr <= a;
		core_wdata <= d;
		core_wr <= w;
		core_rd <= !w;
	endtask
	task idle;
		@(posedge clk_sys);
		core_wr <= 1'b0;
		core_rd <= 1'b0;
		#1;
	endtask
	task sc_port_write;
		acc(8'h04, 8'h20, 1'b1);
		acc(8'h00, 8'h33, 1'b1);
		idle;
		`CHK("fsp", 8'h20, file_select_pointer)
		`CHK("mem_wr", 1'b1, mem_wr)
		`CHK("mem_addr", 8'h20, mem_addr)
		`CHK("mem_wdata", 8'h33, mem_wdata)
		`CHK("eff_addr", 9'h120, eff_addr)
	endtask
	task sc_port_read;
		acc(8'h00, 8'h00, 1'b0);
		idle;
		`CHK("rvalid", 1'b1, core_rvalid)
		`CHK("rd mem_rd", 1'b1, mem_rd)
		`CHK("rdata", 8'h85, core_rdata)
	endtask
	task sc_bank;
		acc(8'h00, 8'h44, 1'b1);
		bank_select_in <= 1'b0;
		idle;
		`CHK("bank wr", 1'b1, mem_wr)
		`CHK("bank addr", 8'h20, mem_addr)
		`CHK("bank eff", 9'h020, eff_addr)
		`CHK("bank wdata", 8'h44, mem_wdata)
		@(posedge clk_sys);
		bank_select_in <= 1'b1;
	endtask
	task sc_direct;
		acc(8'h30, 8'h5c, 1'b1);
		idle;
		`CHK("dir wr", 1'b1, mem_wr)
		`CHK("dir addr", 8'h30, mem_addr)
		`CHK("dir eff", 9'h130, eff_addr)
		acc(8'h30, 8'h00, 1'b0);
		idle;
		`CHK("dir rdata", 8'h95, core_rdata)
		acc(8'h04, 8'h00, 1'b0);
		idle;
		`CHK("ptr rdata", 8'h20, core_rdata)
	endtask
	task sc_ptr_port;
		acc(8'h04, 8'h04, 1'b1);
		acc(8'h00, 8'h28, 1'b1);
		idle;
		`CHK("ptr via port", 8'h28, file_select_pointer)
		`CHK("ptr wr mem", 1'b0, mem_wr)
		acc(8'h00, 8'h00, 1'b0);
		idle;
		`CHK("new ptr addr", 8'h28, mem_addr)
		`CHK("new ptr rdata", 8'h8d, core_rdata)
	endtask
	task sc_self;
		acc(8'h04, 8'h00, 1'b1);
		acc(8'h00, 8'h5a, 1'b1);
		idle;
		`CHK("self wr", 1'b0, mem_wr)
		`CHK("self ptr", 8'h00, file_select_pointer)
		acc(8'h00, 8'h00, 1'b0);
		idle;
		`CHK("self rd", 8'h00, core_rdata)
		`CHK("self rvalid", 1'b1, core_rvalid)
		`CHK("mem_rd", 1'b0, mem_rd)
	endtask
	task results;
		if (n_mismatch == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(posedge clk_sys);
		sys_rst <= 1'b0;
		sc_port_write;
		sc_port_read;
		sc_bank;
		sc_direct;
		sc_ptr_port;
		sc_self;
		results;
	end
endmodule
